/* include/mcal_pkg.sv */
// Constants, channel codes and byte map of the monitor calibration datapath.
// Assumes byte-wide register access and 16-bit converter samples.
package mcal_pkg;

    // ------------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------------
    localparam int AW = 8;                        // Byte address width
    localparam int DW = 8;                        // Byte data width
    localparam int RW = 16;                       // Result width
    localparam int NSEG = 8;                      // Receive power segments
    localparam int NDELIM = 7;                    // Segment boundaries

    // ------------------------------------------------------------------
    // Converter channels
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MCAL_CH_TEMP,
        MCAL_CH_VOLT,
        MCAL_CH_BIAS,
        MCAL_CH_TX,
        MCAL_CH_RX
    } mcal_chan_t;

    // ------------------------------------------------------------------
    // Coefficient byte locations (MSB at the lower address)
    // ------------------------------------------------------------------
    localparam logic [AW-1:0] A_RX_SLOPE0  = 8'h28; // Slope m at +4*m
    localparam logic [AW-1:0] A_RX_OFF0    = 8'h2a; // Offset m at +4*m
    localparam logic [AW-1:0] A_TEMP_OFF   = 8'h4a; // Six-bit offset byte
    localparam logic [AW-1:0] A_VOLT_SLOPE = 8'h4c;
    localparam logic [AW-1:0] A_VOLT_OFF   = 8'h4e;
    localparam logic [AW-1:0] A_BIAS_SLOPE = 8'h50;
    localparam logic [AW-1:0] A_BIAS_OFF   = 8'h52;
    localparam logic [AW-1:0] A_TX_SLOPE   = 8'h54;
    localparam logic [AW-1:0] A_TX_OFF     = 8'h56;
    localparam logic [AW-1:0] A_DELIM0     = 8'hd0; // 14 bytes, 208..221
    localparam logic [AW-1:0] SEG_STRIDE   = 8'h04;

    // ------------------------------------------------------------------
    // Configuration and result bytes
    // ------------------------------------------------------------------
    localparam logic [AW-1:0] A_OEM_CFG1 = 8'hf0;   // oem_config_1
    localparam logic [AW-1:0] A_OEM_CFG3 = 8'hf1;   // oem_config_3
    localparam logic [AW-1:0] A_OEM_CFG6 = 8'hf2;   // oem_config_6
    localparam logic [AW-1:0] A_RES_BASE = 8'h60;   // 5 results, hi then lo
    localparam logic [AW-1:0] A_RES_LAST = 8'h69;
    localparam int BIT_CAL_EN  = 0;                 // In oem_config_3
    localparam int BIT_REF_SEL = 0;                 // In oem_config_1
    localparam int DMODE_LSB   = 5;                 // delimiter_mode [6:5]
    localparam logic [1:0] DMODE_PROG = 2'h1;       // Programmable boundaries
    localparam logic [DW-1:0] CFG_RESET = 8'h00;    // External cal default

    // ------------------------------------------------------------------
    // Arithmetic formats
    // ------------------------------------------------------------------
    localparam int SLOPE_FRAC = 8;                  // Binary point 7/8
    localparam int TOFF_BITS  = 6;                  // Signed half degrees
    localparam int TOFF_SHIFT = 7;                  // Half degree in result LSBs
    localparam logic [RW-1:0] RES_MAX = 16'hffff;

    // Fixed boundaries, ascending, used unless programmable mode
    localparam logic [NDELIM*RW-1:0] FIXED_DELIMS = {
        16'he000, 16'hc000, 16'ha000, 16'h8000,
        16'h6000, 16'h4000, 16'h2000
    };

endpackage : mcal_pkg

/* rtl/mcal_seg_sel.sv */
// Receive power segment selector.
// Assumes the seven boundaries arrive ascending, boundary 0 in the low bits.
`timescale 1ns/1ns
module mcal_seg_sel
    import mcal_pkg::*;
(
    input  wire logic [RW-1:0]        raw_i,    // Raw receive level
    input  wire logic [NDELIM*RW-1:0] delim_i,  // Packed boundaries
    output logic      [2:0]           seg_o     // Chosen segment
);

    // ------------------------------------------------------------------
    // Boundary compares
    // ------------------------------------------------------------------
    logic [NDELIM-1:0] above;                   // Level at or past boundary k

    genvar k;
    generate
        for (k = 0; k < NDELIM; k++) begin : g_cmp
            // One comparator per boundary
            assign above[k] = (raw_i >= delim_i[k*RW +: RW]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Count of passed boundaries is the segment index
    // ------------------------------------------------------------------
    // Counting rather than priority encoding keeps the result monotonic
    // even if software stores boundaries out of order.
    always_comb begin
        seg_o = 3'h0;
        for (int i = 0; i < NDELIM; i++) begin
            seg_o = seg_o + {2'h0, above[i]};
        end
    end

endmodule : mcal_seg_sel

/* rtl/mcal_datapath.sv */
// Monitor calibration datapath: coefficient memory, correction, results.
// Assumes samples come from logic on clk_i, one channel per valid cycle.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ns
module mcal_datapath
    import mcal_pkg::*;
(
    input  wire logic                     clk_i,          // 50 MHz clock
    input  wire logic                     rst_n_i,        // Async reset
    input  wire logic [AW-1:0]            reg_addr_i,     // Byte address
    input  wire logic [DW-1:0]            reg_wdata_i,    // Write data
    input  wire logic                     reg_we_i,       // Write strobe
    input  wire logic                     reg_re_i,       // Read strobe
    output logic      [DW-1:0]            reg_rdata_o,    // Read data, +1
    input  wire logic                     sample_valid_i, // Sample strobe
    input  wire mcal_pkg::mcal_chan_t     sample_chan_i,  // Sample channel
    input  wire logic [RW-1:0]            sample_data_i,  // Left-justified
    output logic                          result_valid_o, // Result stored
    output logic                          ref_supply_o    // 1: VDDA ref
);
    import mcal_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [DW-1:0] mem_r [0:(1<<AW)-1];   // Coefficients, scratch, config
    logic [RW-1:0] res_r [0:4];           // Results by channel code
    logic [DW-1:0] rdata_r;               // Registered read data
    logic          rvalid_r;              // Result stored pulse
    logic          ref_r;                 // Reference select copy

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Two bytes, high byte from the lower address
    function automatic logic [RW-1:0] word_at(input logic [AW-1:0] a);
        logic [AW-1:0] b;
        b = a + 8'h01;
        word_at = {mem_r[a], mem_r[b]};
    endfunction : word_at

    // True when the byte address falls on a result register
    function automatic logic is_res(input logic [AW-1:0] a);
        is_res = (a >= A_RES_BASE) && (a <= A_RES_LAST);
    endfunction : is_res

    // raw * slope + offset, rounded on bit 7, saturated
    function automatic logic [RW-1:0] lin_cal(input logic [RW-1:0] raw,
                                              input logic [RW-1:0] slope,
                                              input logic [RW-1:0] off);
        logic signed [33:0] prod;
        logic signed [33:0] sum;
        logic signed [25:0] rnd;
        prod = $signed({18'h0, raw}) * $signed({18'h0, slope});
        sum  = prod + ($signed({{18{off[15]}}, off}) <<< SLOPE_FRAC);
        rnd  = sum[33:8] + $signed({25'h0, sum[7]});
        if (rnd < 0) begin
            lin_cal = 16'h0000;           // Below range clamps to zero
        end else if (rnd > $signed({10'h0, RES_MAX})) begin
            lin_cal = RES_MAX;            // Above range clamps to full scale
        end else begin
            lin_cal = rnd[15:0];
        end
    endfunction : lin_cal

    // ------------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------------
    logic       cal_en;                    // internal_cal_enable
    logic [1:0] dmode;                     // delimiter_mode
    assign cal_en = mem_r[A_OEM_CFG3][BIT_CAL_EN];
    assign dmode  = mem_r[A_OEM_CFG6][DMODE_LSB +: 2];

    // ------------------------------------------------------------------
    // Boundary source
    // ------------------------------------------------------------------
    logic [NDELIM*RW-1:0] prog_delims;     // Boundaries from scratch bytes
    logic [NDELIM*RW-1:0] delims;          // Boundaries in use

    genvar g;
    generate
        for (g = 0; g < NDELIM; g++) begin : g_delim
            // Boundary g sits at two bytes per step from 208; bytes are indexed
            // here because a function call in an assign would miss memory writes
            assign prog_delims[g*RW +: RW] = {mem_r[A_DELIM0 + AW'(2 * g)],
                                              mem_r[A_DELIM0 + AW'(2 * g + 1)]};
        end
    endgenerate

    // Any code other than programmable falls back to the fixed set
    assign delims = (dmode == DMODE_PROG) ? prog_delims : FIXED_DELIMS;

    // ------------------------------------------------------------------
    // Segment choice
    // ------------------------------------------------------------------
    logic [2:0] seg;                       // Receive power segment

    mcal_seg_sel u_seg (
        .raw_i   (sample_data_i),
        .delim_i (delims),
        .seg_o   (seg)
    );

    // ------------------------------------------------------------------
    // Coefficient fetch and correction
    // ------------------------------------------------------------------
    logic [AW-1:0] rx_base;                // First byte of segment set
    logic [RW-1:0] slope;                  // Selected slope
    logic [RW-1:0] offset;                 // Selected offset
    logic [RW-1:0] toff_ext;               // Scaled temperature offset
    logic [RW-1:0] res_nxt;                // Value to store

    assign rx_base = A_RX_SLOPE0 + AW'(seg) * SEG_STRIDE;

    // Per-channel coefficient pair
    always_comb begin
        slope  = 16'h0000;
        offset = 16'h0000;
        unique case (sample_chan_i)
            MCAL_CH_VOLT: begin
                slope  = word_at(A_VOLT_SLOPE);
                offset = word_at(A_VOLT_OFF);
            end
            MCAL_CH_BIAS: begin
                slope  = word_at(A_BIAS_SLOPE);
                offset = word_at(A_BIAS_OFF);
            end
            MCAL_CH_TX: begin
                slope  = word_at(A_TX_SLOPE);
                offset = word_at(A_TX_OFF);
            end
            MCAL_CH_RX: begin
                slope  = word_at(rx_base);
                offset = word_at(rx_base + (A_RX_OFF0 - A_RX_SLOPE0));
            end
            MCAL_CH_TEMP: begin
                slope  = 16'h0000;        // Not used for temperature
                offset = 16'h0000;
            end
            default: begin
                slope  = 16'h0000;        // Illegal channel code
                offset = 16'h0000;
            end
        endcase
    end

    // Six-bit signed half degrees; the top two bits never enter
    assign toff_ext = RW'($signed(mem_r[A_TEMP_OFF][TOFF_BITS-1:0]))
                      << TOFF_SHIFT;

    // Choose stored value: raw in external mode, corrected otherwise
    always_comb begin
        res_nxt = sample_data_i;
        if (!cal_en) begin
            // Bias and transmit carry an eight-bit code, low byte zero
            if (sample_chan_i == MCAL_CH_BIAS || sample_chan_i == MCAL_CH_TX) begin
                res_nxt = {sample_data_i[15:8], 8'h00};
            end else begin
                res_nxt = sample_data_i;
            end
        end else if (sample_chan_i == MCAL_CH_TEMP) begin
            // Wraps like the converter's own two's-complement reading
            res_nxt = sample_data_i + toff_ext;
        end else begin
            res_nxt = lin_cal(sample_data_i, slope, offset);
        end
    end

    // ------------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 5; i++) begin
                res_r[i] <= 16'h0000;
            end
        end else if (sample_valid_i && sample_chan_i <= MCAL_CH_RX) begin
            res_r[sample_chan_i] <= res_nxt;
        end
    end

    // Stored-result pulse, one cycle after each sample
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= sample_valid_i;
        end
    end

    // ------------------------------------------------------------------
    // Byte memory writes
    // ------------------------------------------------------------------
    // Result bytes are read-only; writes there are dropped
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < (1 << AW); i++) begin
                mem_r[i] <= CFG_RESET;
            end
        end else if (reg_we_i && !is_res(reg_addr_i)) begin
            mem_r[reg_addr_i] <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Data stands one cycle only, zero otherwise
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= 8'h00;
        end else if (reg_re_i) begin
            if (is_res(reg_addr_i)) begin
                // Even offset is the high byte, odd the low byte
                rdata_r <= reg_addr_i[0] ?
                    res_r[3'((reg_addr_i - A_RES_BASE) >> 1)][7:0] :
                    res_r[3'((reg_addr_i - A_RES_BASE) >> 1)][15:8];
            end else begin
                rdata_r <= mem_r[reg_addr_i];
            end
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Monitor reference select pin
    // ------------------------------------------------------------------
    // Registered so the analogue switch never sees decode glitches
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_r <= 1'b0;
        end else begin
            ref_r <= mem_r[A_OEM_CFG1][BIT_REF_SEL];
        end
    end

    assign reg_rdata_o    = rdata_r;
    assign result_valid_o = rvalid_r;
    assign ref_supply_o   = ref_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_raw_volt;
        sample_valid_i && !cal_en && sample_chan_i == MCAL_CH_VOLT;
    endsequence

    sequence s_cal_temp;
        sample_valid_i && cal_en && sample_chan_i == MCAL_CH_TEMP;
    endsequence

    a_raw_voltage: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_raw_volt |=> res_r[MCAL_CH_VOLT] == $past(sample_data_i))
        else $error("raw voltage not stored");

    a_bias_low_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sample_valid_i && !cal_en && sample_chan_i == MCAL_CH_BIAS
        |=> res_r[MCAL_CH_BIAS][7:0] == 8'h00)
        else $error("bias low byte not zero");

    a_tx_low_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sample_valid_i && !cal_en && sample_chan_i == MCAL_CH_TX
        |=> res_r[MCAL_CH_TX] == {$past(sample_data_i[15:8]), 8'h00})
        else $error("transmit raw result wrong");

    a_temp_offset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_cal_temp |=> res_r[MCAL_CH_TEMP] == $past(sample_data_i)
            + {{9{$past(mem_r[A_TEMP_OFF][5])}}, $past(mem_r[A_TEMP_OFF][5:0]), 1'b0} * 16'h0040)
        else $error("temperature offset wrong");

    a_seg_bottom: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sample_data_i < delims[RW-1:0] |-> seg == 3'h0)
        else $error("segment below first boundary not zero");

    a_seg_top: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sample_data_i >= delims[NDELIM*RW-1 -: RW] && delims[NDELIM*RW-1 -: RW] >= delims[RW-1:0]
        && delims == FIXED_DELIMS |-> seg == 3'h7)
        else $error("segment above last boundary not seven");

    a_ref_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        reg_we_i && reg_addr_i == A_OEM_CFG1
        |=> ##1 ref_supply_o == $past(reg_wdata_i[BIT_REF_SEL], 2))
        else $error("reference select not applied");

    a_read_window: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !reg_re_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside its cycle");

    a_valid_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sample_valid_i ##1 !sample_valid_i |-> result_valid_o ##1 !result_valid_o)
        else $error("result pulse wrong");

endmodule : mcal_datapath

/* verif/mcal_conv_model.sv */
// Converter model: issues one sample strobe per request on the device clock.
// Assumes the caller lets each request return before making the next one.
`timescale 1ns/1ns
module mcal_conv_model
    import mcal_pkg::*;
(
    input  wire logic                   clk_i,   // Device clock
    output logic                        valid_o, // Sample strobe
    output mcal_pkg::mcal_chan_t        chan_o,  // Channel code
    output logic [mcal_pkg::RW-1:0]     data_o   // Left-justified sample
);
    // ------------------------------------------------------------------
    // Idle values at time zero
    // ------------------------------------------------------------------
    initial begin
        valid_o = 1'b0;
        chan_o  = MCAL_CH_TEMP;
        data_o  = 16'h5a5a;
    end

    // ------------------------------------------------------------------
    // One sample per call
    // ------------------------------------------------------------------
    // Data is inverted after the strobe so a stale value never matches
    task automatic send(input mcal_chan_t ch, input logic [RW-1:0] d);
        @(posedge clk_i);
        valid_o <= 1'b1;
        chan_o  <= ch;
        data_o  <= d;
        @(posedge clk_i);
        valid_o <= 1'b0;
        data_o  <= ~d;
    endtask : send
endmodule : mcal_conv_model

/* verif/mcal_datapath_tb_top.sv */
// Testbench for the monitor calibration datapath: byte bus tasks and sample tests.
// Assumes the converter model drives the sample port.
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module mcal_datapath_tb_top;
    import mcal_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic          clk_i;
    logic          rst_n_i;
    logic [AW-1:0] reg_addr_i;
    logic [DW-1:0] reg_wdata_i;
    logic          reg_we_i;
    logic          reg_re_i;
    logic [DW-1:0] reg_rdata_o;
    logic          sample_valid_i;
    mcal_chan_t    sample_chan_i;
    logic [RW-1:0] sample_data_i;
    logic          result_valid_o;
    logic          ref_supply_o;
    int            err_total;
    int            num_checks;
    logic [7:0]    b;

    mcal_datapath dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .sample_valid_i(sample_valid_i),
        .sample_chan_i(sample_chan_i), .sample_data_i(sample_data_i),
        .result_valid_o(result_valid_o), .ref_supply_o(ref_supply_o));
    mcal_conv_model u_conv (.clk_i(clk_i), .valid_o(sample_valid_i),
        .chan_o(sample_chan_i), .data_o(sample_data_i));

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Full run is about four hundred cycles, so this limit leaves ample margin
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // Bus tasks and expectation
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_we_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i    <= 1'b0;
    endtask : wr
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        reg_re_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i   <= 1'b0;
        #1 v = reg_rdata_o;
    endtask : rd
    task automatic w16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(8'(a + 1), v[7:0]);
    endtask : w16
    // Sample, then read the result pair high byte first
    task automatic res(input mcal_chan_t ch, input logic [15:0] d, input logic [15:0] e);
        logic [7:0] hi;
        logic [7:0] lo;
        u_conv.send(ch, d);
        #1;
        `CHK(result_valid_o, 1'b1)
        rd(8'(A_RES_BASE + 2 * ch), hi);
        rd(8'(A_RES_BASE + 2 * ch + 1), lo);
        `CHK({hi, lo}, e)
    endtask : res
    // Slope times sample plus offset, rounded on bit 7, clamped to 16 bits
    function automatic logic [15:0] lin(input logic [15:0] d, sl, of);
        longint s;
        s = longint'(d) * longint'(sl) + longint'($signed(of)) * 256;
        s = (s >>> 8) + ((s >>> 7) & 1);
        return (s < 0) ? 16'h0 : (s > 65535) ? 16'hffff : s[15:0];
    endfunction : lin
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        err_total = 0;
        num_checks = 0;
        rst_n_i = 1'b0;
        {reg_addr_i, reg_wdata_i, reg_we_i, reg_re_i} = '0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(A_OEM_CFG3, b);
        `CHK(b, CFG_RESET)
        `CHK(ref_supply_o, 1'b0)
        // External calibration: raw values, low bytes zero for bias and transmit
        res(MCAL_CH_VOLT, 16'h1234, 16'h1234);
        res(MCAL_CH_BIAS, 16'habcd, 16'hab00);
        res(MCAL_CH_TX, 16'h9e37, 16'h9e00);
        wr(A_OEM_CFG1, 8'h01);
        @(posedge clk_i);
        #1 `CHK(ref_supply_o, 1'b1)
        // Internal calibration; top offset bits set but ignored
        wr(A_OEM_CFG3, 8'h01);
        wr(A_TEMP_OFF, 8'hdf);
        res(MCAL_CH_TEMP, 16'h1900, 16'h1900 + 16'(31 * 128));
        for (int i = 0; i < 3; i++) begin
            w16(8'(A_VOLT_SLOPE + 4 * i), 16'h0180 + 16'(i));
            w16(8'(A_VOLT_OFF + 4 * i), 16'hff00 - 16'(i));
            res(mcal_chan_t'(i + 1), 16'h1081 + 16'(i),
                lin(16'h1081 + 16'(i), 16'h0180 + 16'(i), 16'hff00 - 16'(i)));
        end
        // Bias offset from a zero-current reading, stored negated
        w16(A_BIAS_SLOPE, 16'h0100);
        w16(A_BIAS_OFF, 16'h0000);
        res(MCAL_CH_BIAS, 16'h0040, 16'h0040);
        w16(A_BIAS_OFF, 16'hffc0);
        res(MCAL_CH_BIAS, 16'h0040, 16'h0000);
        // Receive segments, distinct coefficient sets, fixed boundaries hit exactly
        // Slopes stay small so no segment saturates and hides a wrong choice
        for (int m = 0; m < NSEG; m++) begin
            w16(8'(A_RX_SLOPE0 + 4 * m), 16'h0040 + 16'(16 * m));
            w16(8'(A_RX_OFF0 + 4 * m), 16'(16 * m));
        end
        for (int m = 0; m < NSEG; m++) begin
            res(MCAL_CH_RX, 16'(8192 * m),
                lin(16'(8192 * m), 16'h0040 + 16'(16 * m), 16'(16 * m)));
        end
        // Programmed boundaries at 0x100 steps, samples just below each next one
        for (int k = 0; k < NDELIM; k++) begin
            w16(8'(A_DELIM0 + 2 * k), 16'(256 * (k + 1)));
        end
        wr(A_OEM_CFG6, 8'h20);
        for (int m = 0; m < NSEG; m++) begin
            res(MCAL_CH_RX, 16'(256 * m + 255),
                lin(16'(256 * m + 255), 16'h0040 + 16'(16 * m), 16'(16 * m)));
        end
        // Modes 10 and 11 fall back to the fixed boundaries
        for (int j = 2; j < 4; j++) begin
            wr(A_OEM_CFG6, 8'(j << DMODE_LSB));
            res(MCAL_CH_RX, 16'h2000, lin(16'h2000, 16'h0050, 16'h0010));
        end
        // One static line: every segment set holds the same pair
        for (int m = 0; m < NSEG; m++) begin
            w16(8'(A_RX_SLOPE0 + 4 * m), 16'h00c0);
            w16(8'(A_RX_OFF0 + 4 * m), 16'hfff0);
        end
        for (int m = 1; m < NSEG; m += 2) begin
            res(MCAL_CH_RX, 16'(8192 * m + 4096),
                lin(16'(8192 * m + 4096), 16'h00c0, 16'hfff0));
        end
        end_sim();
    end
endmodule : mcal_datapath_tb_top
